//--- src/timer16_pkg.sv
package timer16_pkg;

  // ****************************************************************
  // register map, byte addresses on the apb bus
  // ****************************************************************
  localparam logic [11:0] ADDR_CLOCK_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_FORCE_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_COUNT_LOW     = 12'h008;
  localparam logic [11:0] ADDR_COUNT_HIGH    = 12'h00C;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          CLOCK_SEL_LSB   = 0;
  localparam int          CLOCK_SEL_MSB   = 2;
  localparam int          FORCE_A_BIT     = 7;
  localparam int          FORCE_B_BIT     = 6;
  localparam int          FORCE_C_BIT     = 5;
  localparam logic [2:0]  CLOCK_SEL_RESET = 3'h0;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [7:0]  TEMP_RESET      = 8'h00;
  localparam logic [31:0] READ_ZERO       = 32'h0000_0000;

  // ****************************************************************
  // clock source codes and prescaler taps
  // ****************************************************************
  localparam logic [2:0] SRC_STOPPED  = 3'h0;
  localparam logic [2:0] SRC_DIV1     = 3'h1;
  localparam logic [2:0] SRC_DIV8     = 3'h2;
  localparam logic [2:0] SRC_DIV64    = 3'h3;
  localparam logic [2:0] SRC_DIV256   = 3'h4;
  localparam logic [2:0] SRC_DIV1024  = 3'h5;
  localparam logic [2:0] SRC_EXT_FALL = 3'h6;
  localparam logic [2:0] SRC_EXT_RISE = 3'h7;

  localparam int PRESCALE_BITS = 10;
  localparam int TAP_COUNT     = 4;
  // log2 of the divisors 8, 64, 256, 1024
  localparam int TAP_LOG2 [TAP_COUNT] = '{3, 6, 8, 10};

  // ****************************************************************
  // waveform modes without pwm
  // ****************************************************************
  localparam logic [3:0] MODE_NORMAL              = 4'h0;
  localparam logic [3:0] MODE_CLEAR_ON_MATCH_A    = 4'h4;
  localparam logic [3:0] MODE_CLEAR_ON_MATCH_CAPT = 4'hC;

  typedef struct packed {
    logic [2:0] match;    // a, b, c
    logic [5:0] setting;  // a[5:4], b[3:2], c[1:0]
  } force_event_t;

endpackage : timer16_pkg

//--- src/timer16_prescaler.sv
`timescale 1ns/100ps
module timer16_prescaler (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  output logic [timer16_pkg::TAP_COUNT-1:0]     tap_tick
);

  logic [timer16_pkg::PRESCALE_BITS-1:0] div_q;
  logic [timer16_pkg::PRESCALE_BITS-1:0] div_d;

  always_comb begin
    div_d = div_q + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // one pulse each time the low bits wrap
  for (genvar i = 0; i < timer16_pkg::TAP_COUNT; i++) begin : g_tap
    assign tap_tick[i] = &div_q[timer16_pkg::TAP_LOG2[i]-1:0];
  end

  property p_div8_spacing;
    @(posedge pclk) disable iff (!presetn)
      tap_tick[0] |-> ##1 !tap_tick[0] [*7] ##1 tap_tick[0];
  endproperty
  a_div8_spacing: assert property (p_div8_spacing)
    else $error("divide by 8 tick spacing wrong");

endmodule : timer16_prescaler

//--- src/timer16_edge_detect.sv
`timescale 1ns/100ps
module timer16_edge_detect (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      rise_q,
  output logic      fall_q
);

  logic [1:0] sync_q;
  logic [1:0] sync_d;
  logic       prev_q;
  logic       prev_d;
  logic       rise_d;
  logic       fall_d;

  // only the second stage is looked at
  always_comb begin
    sync_d = {sync_q[0], pin_in};
    prev_d = sync_q[1];
    rise_d = sync_q[1] & ~prev_q;
    fall_d = ~sync_q[1] & prev_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q <= 2'h0;
      prev_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      prev_q <= prev_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  property p_rise_pulse;
    @(posedge pclk) disable iff (!presetn)
      (sync_q[1] && !prev_q) |=> (rise_q && !fall_q) ##1 !rise_q;
  endproperty
  a_rise_pulse: assert property (p_rise_pulse)
    else $error("rising edge not seen as single pulse");

endmodule : timer16_edge_detect

//--- src/timer16_clock_force_count.sv
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - selector zero: counter receives no clock and holds its value
// - codes one to five count at clock divided by 1, 8, 64, 256, 1024
// - code six counts falling pin edges, code seven counts rising pin edges
// - pin edges count even when the pin is driven as an output
// - force strobes act only in non-pwm waveform modes
// - force write presents a match now, with the output setting held then
// - forced match raises no flag and never clears the counter
// - force bits always read back as zero
// - counter readable and writable as a high and a low byte
// - byte accesses go through a shared 8-bit high-byte latch
// - counter write suppresses compare matches on the next timer clock
module timer16_clock_force_count (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        external_count_pin,
  input  wire logic [3:0]                  waveform_mode_selector,
  input  wire logic [5:0]                  compare_output_setting,
  output logic      [15:0]                 counter_value,
  output logic                             compare_suppress,
  output timer16_pkg::force_event_t        force_event
);

  // ****************************************************************
  // clock sources
  // ****************************************************************
  logic [timer16_pkg::TAP_COUNT-1:0] tap_tick;
  logic                              pin_rise;
  logic                              pin_fall;

  timer16_prescaler u_prescaler (
    .pclk     (pclk),
    .presetn  (presetn),
    .tap_tick (tap_tick)
  );

  // the pad level is sampled regardless of pin direction
  timer16_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (external_count_pin),
    .rise_q  (pin_rise),
    .fall_q  (pin_fall)
  );

  // ****************************************************************
  // apb access phase
  // ****************************************************************
  logic        access_done;
  logic        wr_done;
  logic        rd_first;
  logic        hit_clock;
  logic        hit_force;
  logic        hit_low;
  logic        hit_high;
  logic        mapped;

  // one wait state: data is prepared in the first access cycle
  assign access_done = psel & penable & pready;
  assign wr_done     = access_done & pwrite;
  assign rd_first    = psel & penable & ~pready & ~pwrite;

  always_comb begin
    hit_clock = 1'b0;
    hit_force = 1'b0;
    hit_low   = 1'b0;
    hit_high  = 1'b0;
    if (paddr == timer16_pkg::ADDR_CLOCK_CONTROL) begin
      hit_clock = 1'b1;
    end else if (paddr == timer16_pkg::ADDR_FORCE_CONTROL) begin
      hit_force = 1'b1;
    end else if (paddr == timer16_pkg::ADDR_COUNT_LOW) begin
      hit_low = 1'b1;
    end else if (paddr == timer16_pkg::ADDR_COUNT_HIGH) begin
      hit_high = 1'b1;
    end
    mapped = hit_clock | hit_force | hit_low | hit_high;
  end

  // ****************************************************************
  // registers and counter
  // ****************************************************************
  logic [2:0]                clock_sel_q;
  logic [2:0]                clock_sel_d;
  logic [7:0]                temp_q;
  logic [7:0]                temp_d;
  logic [15:0]               count_q;
  logic [15:0]               count_d;
  logic                      suppress_q;
  logic                      suppress_d;
  logic                      ready_q;
  logic                      ready_d;
  logic                      slverr_q;
  logic                      slverr_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  timer16_pkg::force_event_t force_q;
  timer16_pkg::force_event_t force_d;
  logic                      timer_tick;
  logic                      non_pwm;
  logic                      count_write;

  always_comb begin
    case (clock_sel_q)
      timer16_pkg::SRC_STOPPED:  timer_tick = 1'b0;
      timer16_pkg::SRC_DIV1:     timer_tick = 1'b1;
      timer16_pkg::SRC_DIV8:     timer_tick = tap_tick[0];
      timer16_pkg::SRC_DIV64:    timer_tick = tap_tick[1];
      timer16_pkg::SRC_DIV256:   timer_tick = tap_tick[2];
      timer16_pkg::SRC_DIV1024:  timer_tick = tap_tick[3];
      timer16_pkg::SRC_EXT_FALL: timer_tick = pin_fall;
      default:                   timer_tick = pin_rise;
    endcase
  end

  assign non_pwm = (waveform_mode_selector == timer16_pkg::MODE_NORMAL)
                 | (waveform_mode_selector == timer16_pkg::MODE_CLEAR_ON_MATCH_A)
                 | (waveform_mode_selector == timer16_pkg::MODE_CLEAR_ON_MATCH_CAPT);
  assign count_write = wr_done & hit_low;

  always_comb begin
    clock_sel_d = clock_sel_q;
    temp_d      = temp_q;
    count_d     = count_q;
    suppress_d  = suppress_q;
    ready_d     = psel & penable & ~pready;
    slverr_d    = psel & penable & ~pready & ~mapped;
    rdata_d     = timer16_pkg::READ_ZERO;
    force_d     = '{match: 3'h0, setting: force_q.setting};

    // a forced match never touches the count or any flag
    if (timer_tick) begin
      count_d    = count_q + 16'h0001;
      suppress_d = 1'b0;
    end
    if (wr_done && hit_clock) begin
      clock_sel_d = pwdata[timer16_pkg::CLOCK_SEL_MSB:timer16_pkg::CLOCK_SEL_LSB];
    end
    if (wr_done && hit_high) begin
      temp_d = pwdata[7:0];
    end
    // write beats a tick in the same cycle
    if (count_write) begin
      count_d    = {temp_q, pwdata[7:0]};
      suppress_d = 1'b1;
    end
    // bits 4:0 are ignored on write, software keeps them zero
    if (wr_done && hit_force && non_pwm) begin
      force_d.match   = {pwdata[timer16_pkg::FORCE_A_BIT],
                         pwdata[timer16_pkg::FORCE_B_BIT],
                         pwdata[timer16_pkg::FORCE_C_BIT]};
      force_d.setting = compare_output_setting;
    end

    if (rd_first) begin
      if (hit_clock) begin
        rdata_d = {29'h0000_0000, clock_sel_q};
      end else if (hit_low) begin
        rdata_d = {24'h00_0000, count_q[7:0]};
        temp_d  = count_q[15:8];
      end else if (hit_high) begin
        rdata_d = {24'h00_0000, temp_q};
      end
      // force register falls through as zero
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_sel_q <= timer16_pkg::CLOCK_SEL_RESET;
      temp_q      <= timer16_pkg::TEMP_RESET;
      count_q     <= timer16_pkg::COUNT_RESET;
      suppress_q  <= 1'b0;
      ready_q     <= 1'b0;
      slverr_q    <= 1'b0;
      rdata_q     <= timer16_pkg::READ_ZERO;
      force_q     <= '0;
    end else begin
      clock_sel_q <= clock_sel_d;
      temp_q      <= temp_d;
      count_q     <= count_d;
      suppress_q  <= suppress_d;
      ready_q     <= ready_d;
      slverr_q    <= slverr_d;
      rdata_q     <= rdata_d;
      force_q     <= force_d;
    end
  end

  assign prdata           = rdata_q;
  assign pready           = ready_q;
  assign pslverr          = slverr_q;
  assign counter_value    = count_q;
  assign compare_suppress = suppress_q;
  assign force_event      = force_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_stopped_holds;
    @(posedge pclk) disable iff (!presetn)
      (clock_sel_q == timer16_pkg::SRC_STOPPED && !count_write) |=> $stable(count_q);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds)
    else $error("counter moved with no clock source");

  property p_div1_counts;
    @(posedge pclk) disable iff (!presetn)
      (clock_sel_q == timer16_pkg::SRC_DIV1 && !count_write)
        |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_div1_counts: assert property (p_div1_counts)
    else $error("undivided clock did not advance counter");

  property p_ext_rise;
    @(posedge pclk) disable iff (!presetn)
      (clock_sel_q == timer16_pkg::SRC_EXT_RISE && pin_rise && !count_write)
        |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("rising pin edge not counted");

  property p_pwm_ignores_force;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && hit_force && !non_pwm) |=> force_q.match == 3'h0;
  endproperty
  a_pwm_ignores_force: assert property (p_pwm_ignores_force)
    else $error("force strobe acted in a pwm mode");

  sequence s_force_a_write;
    wr_done && hit_force && non_pwm && pwdata[timer16_pkg::FORCE_A_BIT];
  endsequence
  property p_force_now;
    @(posedge pclk) disable iff (!presetn)
      s_force_a_write |=> force_q.match[2] && force_q.setting == $past(compare_output_setting)
                          ##1 !force_q.match[2];
  endproperty
  a_force_now: assert property (p_force_now)
    else $error("forced match missing or setting wrong");

  property p_force_no_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_done && hit_force && clock_sel_q == timer16_pkg::SRC_STOPPED) |=> $stable(count_q);
  endproperty
  a_force_no_clear: assert property (p_force_no_clear)
    else $error("forced match changed the counter");

  property p_force_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (access_done && !pwrite && hit_force) |-> prdata == timer16_pkg::READ_ZERO;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("force register read non-zero");

  property p_low_read_latches;
    @(posedge pclk) disable iff (!presetn)
      (rd_first && hit_low) |=> temp_q == $past(count_q[15:8])
                                && prdata[7:0] == $past(count_q[7:0]);
  endproperty
  a_low_read_latches: assert property (p_low_read_latches)
    else $error("low byte read did not latch high byte");

  property p_write_suppress;
    @(posedge pclk) disable iff (!presetn)
      count_write |=> suppress_q && count_q == {$past(temp_q), $past(pwdata[7:0])};
  endproperty
  a_write_suppress: assert property (p_write_suppress)
    else $error("counter write not applied or not suppressed");

  property p_ext_fall;
    @(posedge pclk) disable iff (!presetn)
      (clock_sel_q == timer16_pkg::SRC_EXT_FALL && pin_fall && !count_write)
        |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("falling pin edge not counted");

  // a divided source must not count between its ticks
  property p_div8_counts;
    @(posedge pclk) disable iff (!presetn)
      (clock_sel_q == timer16_pkg::SRC_DIV8 && !tap_tick[0] && !count_write)
        |=> $stable(count_q);
  endproperty
  a_div8_counts: assert property (p_div8_counts)
    else $error("divide by 8 source counted off its tick");

  property p_suppress_ends;
    @(posedge pclk) disable iff (!presetn)
      (suppress_q && timer_tick && !count_write) |=> !suppress_q;
  endproperty
  a_suppress_ends: assert property (p_suppress_ends)
    else $error("match suppression outlived the next timer clock");

  // software relies on exactly one wait state
  property p_one_wait_state;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready;
  endproperty
  a_one_wait_state: assert property (p_one_wait_state)
    else $error("access phase not answered after one wait state");

endmodule : timer16_clock_force_count

//--- dv/tb_timer16_clock_force_count.sv
`timescale 1ns/100ps
module tb_timer16_clock_force_count;

  // ****************************************************************
  // clock, reset and stimulus signals
  // ****************************************************************
  logic                      pclk;
  logic                      presetn;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [11:0]               paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      external_count_pin;
  logic [3:0]                waveform_mode_selector;
  logic [5:0]                compare_output_setting;
  logic [15:0]               counter_value;
  logic                      compare_suppress;
  timer16_pkg::force_event_t force_event;
  int                        bad_count;
  int                        cmp_count;
  logic [31:0]               rdata_v;
  logic                      err_v;
  logic [2:0]                seen_match;
  logic [5:0]                seen_set;
  logic [15:0]               c0;

  timer16_clock_force_count u_dut (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .external_count_pin     (external_count_pin),
    .waveform_mode_selector (waveform_mode_selector),
    .compare_output_setting (compare_output_setting),
    .counter_value          (counter_value),
    .compare_suppress       (compare_suppress),
    .force_event            (force_event)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata_v = prdata;
    err_v   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask : check

  task automatic rd_check(input string name, input logic [11:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(name, exp, rdata_v);
  endtask : rd_check

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      external_count_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      external_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (8) @(posedge pclk);
  endtask : pulses

  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    complete_run();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    logic [3:0] modes [8];
    modes = '{4'h0, 4'h4, 4'hC, 4'h1, 4'h5, 4'hD, 4'hE, 4'hF};
    bad_count = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    external_count_pin = 1'b0;
    waveform_mode_selector = 4'h0;
    compare_output_setting = 6'h00;
    seen_match = 3'h0;
    seen_set = 6'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_check("clock_ctrl", timer16_pkg::ADDR_CLOCK_CONTROL, 32'h0000_0000);
    rd_check("count_low", timer16_pkg::ADDR_COUNT_LOW, 32'h0000_0000);
    rd_check("count_high", timer16_pkg::ADDR_COUNT_HIGH, 32'h0000_0000);
    // high byte goes to the shared latch first, low write commits both
    apb(1'b1, timer16_pkg::ADDR_COUNT_HIGH, 32'h0000_00A5);
    apb(1'b1, timer16_pkg::ADDR_COUNT_LOW, 32'h0000_005A);
    // the write lands at the completing edge, so look one edge later
    @(posedge pclk);
    check("count_port", 32'h0000_A55A, {16'h0000, counter_value});
    check("suppress", 32'h0000_0001, {31'h0, compare_suppress});
    rd_check("count_low_rb", timer16_pkg::ADDR_COUNT_LOW, 32'h0000_005A);
    rd_check("count_high_rb", timer16_pkg::ADDR_COUNT_HIGH, 32'h0000_00A5);
    repeat (50) @(posedge pclk);
    check("stopped", 32'h0000_A55A, {16'h0000, counter_value});
    for (int i = 0; i < 8; i++) begin
      waveform_mode_selector <= modes[i];
      compare_output_setting <= 6'h1B ^ 6'(i);
      // reserved bits 4:0 kept zero
      apb(1'b1, timer16_pkg::ADDR_FORCE_CONTROL, 32'h0000_00E0);
      // match stands only in the cycle after the completing edge
      @(posedge pclk);
      seen_match = force_event.match;
      seen_set   = force_event.setting;
      @(posedge pclk);
      check("force_match", (i < 3) ? 32'h7 : 32'h0, {29'h0, seen_match});
      if (i < 3) check("force_set", {26'h0, 6'h1B ^ 6'(i)}, {26'h0, seen_set});
      check("force_drop", 32'h0, {29'h0, force_event.match});
      check("force_no_clear", 32'h0000_A55A, {16'h0000, counter_value});
      rd_check("force_read", timer16_pkg::ADDR_FORCE_CONTROL, 32'h0000_0000);
    end
    waveform_mode_selector <= 4'h0;
    for (int b = 5; b < 8; b++) begin
      apb(1'b1, timer16_pkg::ADDR_FORCE_CONTROL, 32'h1 << b);
      @(posedge pclk);
      seen_match = force_event.match;
      check("force_bit", 32'h1 << (b - 5), {29'h0, seen_match});
    end
    apb(1'b1, 12'h010, 32'h0000_0001);
    check("unmapped_wr_err", 32'h1, {31'h0, err_v});
    rd_check("unmapped_rd", 12'h010, 32'h0000_0000);
    check("unmapped_rd_err", 32'h1, {31'h0, err_v});
    rd_check("clock_ctrl_kept", timer16_pkg::ADDR_CLOCK_CONTROL, 32'h0000_0000);
    // free prescaler: a whole number of periods gives an exact tick count
    for (int s = 1; s <= 5; s++) begin
      apb(1'b1, timer16_pkg::ADDR_CLOCK_CONTROL, 32'(s));
      repeat (2) @(posedge pclk);
      c0 = counter_value;
      repeat ((s == 1) ? 4 : 4 << timer16_pkg::TAP_LOG2[s - 2]) @(posedge pclk);
      check("prescale_delta", 32'h4, {16'h0000, counter_value - c0});
      if (s == 1) check("suppress_gone", 32'h0, {31'h0, compare_suppress});
    end
    rd_check("clock_ctrl_rb", timer16_pkg::ADDR_CLOCK_CONTROL, 32'h0000_0005);
    for (int s = 6; s <= 7; s++) begin
      apb(1'b1, timer16_pkg::ADDR_CLOCK_CONTROL, 32'(s));
      repeat (2) @(posedge pclk);
      c0 = counter_value;
      pulses(3);
      check("pin_delta", 32'h3, {16'h0000, counter_value - c0});
    end
    apb(1'b1, timer16_pkg::ADDR_CLOCK_CONTROL, 32'h0000_0000);
    c0 = counter_value;
    pulses(2);
    check("pin_stopped", {16'h0000, c0}, {16'h0000, counter_value});
    complete_run();
  end

endmodule : tb_timer16_clock_force_count
